// ---- logic/tpsc_pkg.sv ----
package tpsc_pkg;

  // Register addresses
  localparam logic [5:0] ADDR_POWER_STREAM = 6'h07;
  localparam logic [5:0] ADDR_POWER_AMP    = 6'h08;
  localparam logic [5:0] ADDR_PIN_CLK_TMR  = 6'h09;
  localparam logic [5:0] ADDR_CLKO_CTL     = 6'h0A;
  localparam logic [5:0] ADDR_STATUS       = 6'h24;

  // power_stream_control fields
  localparam int PSC_LOAD_BIT   = 15;
  localparam int PSC_FLOAT_BIT  = 11;
  localparam int PSC_KEEP_BIT   = 9;
  localparam int PSC_SMASK_BIT  = 7;
  localparam int PSC_RMASK_BIT  = 6;
  localparam int PSC_STREAM_BIT = 5;
  localparam int PSC_DEEP_BIT   = 1;
  localparam int PSC_TIMED_BIT  = 0;
  // power_amp_gate, pin_clock_timer_control and clock out control fields
  localparam int PAG_EN_BIT     = 15;
  localparam int PCT_ALT_BIT    = 7;
  localparam int PCT_CLKEN_BIT  = 5;
  localparam int PCT_DIV_LSB    = 0;
  localparam int CLKO_DIV_LSB   = 0;
  localparam int SEL_W          = 3;
  // Status positions shared between faults and stream done flags
  localparam int STAT_POS_SEND  = 0;
  localparam int STAT_POS_RECV  = 1;

  // Reset values and writable masks
  localparam logic [15:0] PSC_RST   = 16'h0800;
  localparam logic [15:0] PAG_RST   = 16'h8000;
  localparam logic [15:0] PCT_RST   = 16'h0020;
  localparam logic [15:0] CLKO_RST  = 16'h7E00;
  localparam logic [15:0] PSC_WMASK = 16'h8AE3;
  localparam logic [15:0] PAG_WMASK = 16'h8000;
  localparam logic [15:0] PCT_WMASK = 16'h00A7;
  localparam logic [15:0] CLKO_WMASK = 16'hFF07;

  // Serial frame shape
  localparam logic [4:0] HDR_BITS   = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int         HDR_READ_BIT = 7;

  // Timing
  localparam int CLK_FREQ_KHZ       = 250000;
  localparam int SLEEP_CLKO_MAX_KHZ = 1000;
  localparam int SLEEP_MIN_HALF_INT =
    (CLK_FREQ_KHZ + 2 * SLEEP_CLKO_MAX_KHZ - 1) / (2 * SLEEP_CLKO_MAX_KHZ);
  localparam logic [15:0] SLEEP_MIN_HALF   = SLEEP_MIN_HALF_INT[15:0];
  localparam logic [7:0]  CLKO_STOP_CYCLES = 8'h80;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ce_n;
  } tpsc_spi_pins_t;

  typedef struct packed {
    logic send_finish;
    logic receive_finish;
    logic buffer_address_fault;
    logic arbiter_conflict_fault;
  } tpsc_events_t;

endpackage

// ---- logic/tpsc_ctrl_bank.sv ----
`timescale 1ns/1ps
module tpsc_ctrl_bank #(
  parameter logic [127:0] CLKO_HALF_TABLE  = {16'd128, 16'd64, 16'd32, 16'd16,
                                              16'd8, 16'd4, 16'd2, 16'd1},
  parameter logic [127:0] TMR_PERIOD_TABLE = {16'd128, 16'd64, 16'd32, 16'd16,
                                              16'd8, 16'd4, 16'd2, 16'd1}
) (
  // Clock, reset, enable
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    clk_en,
  // Serial port pins
  input  wire tpsc_pkg::tpsc_spi_pins_t spi_pins,
  output logic                         miso_out,
  output logic                         miso_oe,
  // Event timer
  input  wire logic [23:0]             timer_compare_one_value,
  output logic                         event_timer_load,
  output logic [23:0]                  event_timer_load_value,
  output logic                         event_timer_tick,
  // Events and interrupt
  input  wire tpsc_pkg::tpsc_events_t  events,
  output logic                         interrupt_request_n,
  // Power and mode state
  output logic                         clock_out_pin,
  output logic                         power_amp_enable,
  output logic                         word_streaming,
  output logic                         deep_sleep_active,
  output logic                         timed_sleep_active,
  // General pins
  input  wire logic                    out_of_idle,
  input  wire logic                    crc_cca_valid,
  input  wire logic [1:0]              gpio_out_req,
  input  wire logic [1:0]              gpio_oe_req,
  output logic [1:0]                   general_pin_out,
  output logic [1:0]                   general_pin_oe
);

  logic [2:0]  sync1, sync2, sync3, pins_f;
  logic        sclk_d;
  logic [4:0]  bit_cnt;
  logic [22:0] rx_shift;
  logic        is_read, wr_pend, rd_done;
  logic [5:0]  addr;
  logic [15:0] wr_data, tx_shift;
  logic [15:0] psc, pag, pct, clko;
  logic        flag_send, flag_recv, flag_buf, flag_arb;
  logic [7:0]  stop_cnt;
  logic [15:0] clko_cnt, tmr_cnt;

  // Pin synchronisers: a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sync1[gi]  <= (gi == 0) ? 1'b1 : 1'b0;
          sync2[gi]  <= (gi == 0) ? 1'b1 : 1'b0;
          sync3[gi]  <= (gi == 0) ? 1'b1 : 1'b0;
          pins_f[gi] <= (gi == 0) ? 1'b1 : 1'b0;
        end else if (clk_en) begin
          sync1[gi] <= spi_pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pins_f[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  wire ce_n_f    = pins_f[0];
  wire mosi_f    = pins_f[1];
  wire sclk_f    = pins_f[2];
  wire sclk_rise = sclk_f & ~sclk_d;
  wire sclk_fall = ~sclk_f & sclk_d;
  wire [7:0] hdr = {rx_shift[6:0], mosi_f};

  wire stat_send = psc[tpsc_pkg::PSC_STREAM_BIT] ? flag_send : flag_buf;
  wire stat_recv = psc[tpsc_pkg::PSC_STREAM_BIT] ? flag_recv : flag_arb;

  function automatic logic [15:0] read_mux(input logic [5:0] a);
    logic [15:0] r;
    r = 16'h0000;
    unique case (a)
      tpsc_pkg::ADDR_POWER_STREAM: r = psc;
      tpsc_pkg::ADDR_POWER_AMP:    r = pag;
      tpsc_pkg::ADDR_PIN_CLK_TMR:  r = pct;
      tpsc_pkg::ADDR_CLKO_CTL:     r = clko;
      tpsc_pkg::ADDR_STATUS: begin
        r[tpsc_pkg::STAT_POS_SEND] = stat_send;
        r[tpsc_pkg::STAT_POS_RECV] = stat_recv;
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // Serial frame: 8 header bits (bit 7 read), then 16 data bits, MSB first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d   <= 1'b0;
      bit_cnt  <= 5'h00;
      rx_shift <= 23'h000000;
      is_read  <= 1'b0;
      addr     <= 6'h00;
      wr_pend  <= 1'b0;
      rd_done  <= 1'b0;
      wr_data  <= 16'h0000;
    end else if (clk_en) begin
      sclk_d  <= sclk_f;
      wr_pend <= 1'b0;
      rd_done <= 1'b0;
      if (ce_n_f) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise && bit_cnt != tpsc_pkg::FRAME_BITS) begin
        rx_shift <= {rx_shift[21:0], mosi_f};
        bit_cnt  <= bit_cnt + 5'h01;
        if (bit_cnt == tpsc_pkg::HDR_BITS - 5'h01) begin
          is_read <= hdr[tpsc_pkg::HDR_READ_BIT];
          addr    <= hdr[5:0];
        end
        if (bit_cnt == tpsc_pkg::FRAME_BITS - 5'h01) begin
          wr_pend <= ~is_read;
          rd_done <= is_read;
          wr_data <= {rx_shift[14:0], mosi_f};
        end
      end
    end
  end

  // MISO: data shifts out on falling clock; idle level follows float select
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
      tx_shift <= 16'h0000;
    end else if (clk_en) begin
      if (ce_n_f) begin
        miso_out <= 1'b0;
        miso_oe  <= ~psc[tpsc_pkg::PSC_FLOAT_BIT];
      end else begin
        miso_oe <= 1'b1;
        if (sclk_rise && bit_cnt == tpsc_pkg::HDR_BITS - 5'h01) begin
          tx_shift <= read_mux(hdr[5:0]);
        end else if (sclk_fall && bit_cnt >= tpsc_pkg::HDR_BITS) begin
          miso_out <= tx_shift[15];
          tx_shift <= {tx_shift[14:0], 1'b0};
        end
      end
    end
  end

  // Register writes and event timer load
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      psc                    <= tpsc_pkg::PSC_RST;
      pag                    <= tpsc_pkg::PAG_RST;
      pct                    <= tpsc_pkg::PCT_RST;
      clko                   <= tpsc_pkg::CLKO_RST;
      event_timer_load       <= 1'b0;
      event_timer_load_value <= 24'h000000;
    end else if (clk_en) begin
      event_timer_load <= 1'b0;
      if (wr_pend) begin
        unique case (addr)
          tpsc_pkg::ADDR_POWER_STREAM: begin
            psc <= wr_data & tpsc_pkg::PSC_WMASK;
            if (wr_data[tpsc_pkg::PSC_LOAD_BIT] && !psc[tpsc_pkg::PSC_LOAD_BIT]) begin
              event_timer_load       <= 1'b1;
              event_timer_load_value <= timer_compare_one_value;
            end
          end
          tpsc_pkg::ADDR_POWER_AMP:   pag  <= wr_data & tpsc_pkg::PAG_WMASK;
          tpsc_pkg::ADDR_PIN_CLK_TMR: pct  <= wr_data & tpsc_pkg::PCT_WMASK;
          tpsc_pkg::ADDR_CLKO_CTL:    clko <= wr_data & tpsc_pkg::CLKO_WMASK;
          default: ;
        endcase
      end
    end
  end

  assign power_amp_enable   = pag[tpsc_pkg::PAG_EN_BIT];
  assign word_streaming     = psc[tpsc_pkg::PSC_STREAM_BIT];
  assign deep_sleep_active  = psc[tpsc_pkg::PSC_DEEP_BIT];
  assign timed_sleep_active = psc[tpsc_pkg::PSC_TIMED_BIT];

  // Sticky status flags: read of status clears, a new event wins
  wire stat_clr = rd_done && addr == tpsc_pkg::ADDR_STATUS;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag_send           <= 1'b0;
      flag_recv           <= 1'b0;
      flag_buf            <= 1'b0;
      flag_arb            <= 1'b0;
      interrupt_request_n <= 1'b1;
    end else if (clk_en) begin
      flag_send <= events.send_finish | (flag_send & ~stat_clr);
      flag_recv <= events.receive_finish | (flag_recv & ~stat_clr);
      flag_buf  <= events.buffer_address_fault | (flag_buf & ~stat_clr);
      flag_arb  <= events.arbiter_conflict_fault | (flag_arb & ~stat_clr);
      interrupt_request_n <=
        ~((flag_send & psc[tpsc_pkg::PSC_SMASK_BIT]) |
          (flag_recv & psc[tpsc_pkg::PSC_RMASK_BIT]));
    end
  end

  // Clock out: divider table, sleep rate limit, stop delay
  wire [2:0]  clko_sel  = clko[tpsc_pkg::CLKO_DIV_LSB +: tpsc_pkg::SEL_W];
  wire [15:0] half_tab  = CLKO_HALF_TABLE[clko_sel * 16 +: 16];
  wire        timed     = psc[tpsc_pkg::PSC_TIMED_BIT];
  wire [15:0] half_use  = (timed && half_tab < tpsc_pkg::SLEEP_MIN_HALF) ?
                          tpsc_pkg::SLEEP_MIN_HALF : half_tab;
  wire        clko_halt = psc[tpsc_pkg::PSC_DEEP_BIT] ||
                          (timed && !psc[tpsc_pkg::PSC_KEEP_BIT] &&
                           stop_cnt == tpsc_pkg::CLKO_STOP_CYCLES);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_cnt <= 8'h00;
    end else if (clk_en) begin
      if (!timed) begin
        stop_cnt <= 8'h00;
      end else if (stop_cnt != tpsc_pkg::CLKO_STOP_CYCLES) begin
        stop_cnt <= stop_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clko_cnt      <= 16'h0000;
      clock_out_pin <= 1'b0;
    end else if (clk_en) begin
      if (!pct[tpsc_pkg::PCT_CLKEN_BIT]) begin
        clko_cnt      <= 16'h0000;
        clock_out_pin <= 1'b0;
      end else if (!clko_halt) begin
        if (clko_cnt + 16'h0001 >= half_use) begin
          clko_cnt      <= 16'h0000;
          clock_out_pin <= ~clock_out_pin;
        end else begin
          clko_cnt <= clko_cnt + 16'h0001;
        end
      end
    end
  end

  // Event timer base tick; the time base stops only in deep sleep
  wire [2:0]  tmr_sel = pct[tpsc_pkg::PCT_DIV_LSB +: tpsc_pkg::SEL_W];
  wire [15:0] tmr_per = TMR_PERIOD_TABLE[tmr_sel * 16 +: 16];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_cnt          <= 16'h0000;
      event_timer_tick <= 1'b0;
    end else if (clk_en) begin
      event_timer_tick <= 1'b0;
      if (psc[tpsc_pkg::PSC_DEEP_BIT]) begin
        tmr_cnt <= 16'h0000;
      end else if (tmr_cnt + 16'h0001 >= tmr_per) begin
        tmr_cnt          <= 16'h0000;
        event_timer_tick <= 1'b1;
      end else begin
        tmr_cnt <= tmr_cnt + 16'h0001;
      end
    end
  end

  // General pins: status alternate function or ordinary I/O
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      general_pin_out <= 2'b00;
      general_pin_oe  <= 2'b00;
    end else if (clk_en) begin
      if (pct[tpsc_pkg::PCT_ALT_BIT]) begin
        general_pin_out <= {crc_cca_valid, out_of_idle};
        general_pin_oe  <= 2'b11;
      end else begin
        general_pin_out <= gpio_out_req;
        general_pin_oe  <= gpio_oe_req;
      end
    end
  end

  // Cycles in timed sleep with the keep bit clear, counted apart from the stop logic
  logic [8:0] stop_chk_cnt;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_chk_cnt <= 9'h000;
    end else if (clk_en) begin
      stop_chk_cnt <= (!timed || psc[tpsc_pkg::PSC_KEEP_BIT]) ? 9'h000 :
                      stop_chk_cnt + {8'h00, stop_chk_cnt != 9'h1FF};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn || !clk_en);

  a_timer_load_edge: assert property (
    event_timer_load |-> $past(wr_pend) && $past(addr) == tpsc_pkg::ADDR_POWER_STREAM
      && psc[tpsc_pkg::PSC_LOAD_BIT] && !$past(psc[tpsc_pkg::PSC_LOAD_BIT]))
    else $error("timer load without a rising strobe write");
  a_miso_idle_drive: assert property (
    ce_n_f && $past(ce_n_f) && $stable(psc) |=> !miso_out &&
      miso_oe == !$past(psc[tpsc_pkg::PSC_FLOAT_BIT]))
    else $error("MISO idle state wrong");
  a_clko_stop_delay: assert property (
    stop_chk_cnt > 9'd130 && $stable(pct) |-> $stable(clock_out_pin))
    else $error("clock out still toggling after stop delay");
  a_clko_sleep_rate: assert property (
    timed && $changed(clock_out_pin) |-> ##1 (!$changed(clock_out_pin) || !timed) [*8])
    else $error("clock out too fast in timed sleep");
  a_send_irq_mask: assert property (
    events.send_finish ##1 psc[tpsc_pkg::PSC_SMASK_BIT] |=> !interrupt_request_n)
    else $error("send finish interrupt missing");
  a_recv_irq_mask: assert property (
    $past(!psc[tpsc_pkg::PSC_SMASK_BIT] && !psc[tpsc_pkg::PSC_RMASK_BIT])
      |-> interrupt_request_n)
    else $error("interrupt while both masks clear");
  a_stream_status_pos: assert property (
    psc[tpsc_pkg::PSC_STREAM_BIT] && !wr_pend && events.send_finish
      |=> stat_send)
    else $error("send finish not in status position");
  a_clko_hold_low: assert property (
    !pct[tpsc_pkg::PCT_CLKEN_BIT] |=> !clock_out_pin)
    else $error("clock out not held low");
  a_deep_no_tick: assert property (
    psc[tpsc_pkg::PSC_DEEP_BIT] ##1 psc[tpsc_pkg::PSC_DEEP_BIT] |-> !event_timer_tick)
    else $error("time base runs in deep sleep");
  a_alt_pins: assert property (
    pct[tpsc_pkg::PCT_ALT_BIT] |=> general_pin_oe == 2'b11
      && general_pin_out == $past({crc_cca_valid, out_of_idle}))
    else $error("alternate status pins wrong");

endmodule

// ---- tb/tpsc_spi_host.sv ----
`timescale 1ns/1ps
module tpsc_spi_host (
  // Pins toward the device
  output tpsc_pkg::tpsc_spi_pins_t pins,
  input  wire logic                miso
);
  localparam realtime HALF = 62.5;

  // Clock idles low and stands still between frames
  initial begin
    pins = '{sclk: 1'b0, mosi: 1'b0, ce_n: 1'b1};
  end

  // Header then word, MSB first; read data taken on rising edges 9..24
  task automatic xfer(input logic rd, input logic [5:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic [23:0] sh;
    int          i;
    sh = {rd, 1'b0, addr, wdata};
    rdata = 16'h0000;
    pins.ce_n = 1'b0;
    #HALF;
    for (i = 23; i >= 0; i--) begin
      pins.mosi = sh[i];
      #HALF;
      pins.sclk = 1'b1;
      if (i < 16) rdata[i] = miso;
      #HALF;
      pins.sclk = 1'b0;
    end
    // Released data line must not keep its last value
    pins.mosi = ~pins.mosi;
    #HALF;
    pins.ce_n = 1'b1;
    #(2 * HALF);
  endtask

  // A further load needs the strobe written low first
  task automatic rearm(input logic [15:0] base, output logic [15:0] rdata);
    xfer(1'b0, tpsc_pkg::ADDR_POWER_STREAM, base & 16'h7FFF, rdata);
    xfer(1'b0, tpsc_pkg::ADDR_POWER_STREAM, base | 16'h8000, rdata);
  endtask
endmodule

// ---- tb/tpsc_ctrl_bank_tb.sv ----
`timescale 1ns/1ps
module tpsc_ctrl_bank_tb;
  logic                     sys_clk = 1'b0;
  logic                     rstn    = 1'b0;
  logic                     clk_en;
  tpsc_pkg::tpsc_spi_pins_t spi_pins;
  logic                     miso_out;
  logic                     miso_oe;
  logic [23:0]              tcv;
  logic                     event_timer_load;
  logic [23:0]              event_timer_load_value;
  logic                     event_timer_tick;
  tpsc_pkg::tpsc_events_t   events;
  logic                     interrupt_request_n;
  logic                     clock_out_pin;
  logic                     power_amp_enable;
  logic                     word_streaming;
  logic                     deep_sleep_active;
  logic                     timed_sleep_active;
  logic                     out_of_idle;
  logic                     crc_cca_valid;
  logic [1:0]               gpio_out_req;
  logic [1:0]               gpio_oe_req;
  logic [1:0]               general_pin_out;
  logic [1:0]               general_pin_oe;
  wire                      miso_wire = miso_oe ? miso_out : 1'bz;
  logic                     clko_q = 1'b0;
  logic [15:0]              rd;
  int                       mismatches = 0;
  int                       cmp_count = 0;
  int                       toggles = 0;
  int                       ticks = 0;
  int                       loads = 0;
  int                       tg;
  int                       tk;

  tpsc_ctrl_bank i_tpsc_ctrl_bank (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .spi_pins(spi_pins),
    .miso_out(miso_out), .miso_oe(miso_oe), .timer_compare_one_value(tcv),
    .event_timer_load(event_timer_load), .event_timer_load_value(event_timer_load_value),
    .event_timer_tick(event_timer_tick), .events(events),
    .interrupt_request_n(interrupt_request_n), .clock_out_pin(clock_out_pin),
    .power_amp_enable(power_amp_enable), .word_streaming(word_streaming),
    .deep_sleep_active(deep_sleep_active), .timed_sleep_active(timed_sleep_active),
    .out_of_idle(out_of_idle), .crc_cca_valid(crc_cca_valid), .gpio_out_req(gpio_out_req),
    .gpio_oe_req(gpio_oe_req), .general_pin_out(general_pin_out),
    .general_pin_oe(general_pin_oe)
  );

  tpsc_spi_host i_tpsc_spi_host (.pins(spi_pins), .miso(miso_wire));

  always #2 sys_clk = ~sys_clk;

  // Edge, tick and load counters on the outputs
  always @(posedge sys_clk) begin
    clko_q <= clock_out_pin;
    if (clock_out_pin !== clko_q) toggles++;
    if (event_timer_tick === 1'b1) ticks++;
    if (event_timer_load === 1'b1) loads++;
  end

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("MISMATCH at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    i_tpsc_spi_host.xfer(1'b0, a, d, rd);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
    i_tpsc_spi_host.xfer(1'b1, a, 16'h0000, rd);
    chk_val({8'h00, rd}, {8'h00, exp});
  endtask

  task automatic span(input int n);
    int a;
    int b;
    a = toggles;
    b = ticks;
    repeat (n) @(posedge sys_clk);
    tg = toggles - a;
    tk = ticks - b;
  endtask

  task automatic pulse(input tpsc_pkg::tpsc_events_t e);
    @(negedge sys_clk) events = e;
    @(negedge sys_clk) events = '0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #300us;
    mismatches++;
    end_sim();
  end

  initial begin
    clk_en = 1'b1;
    tcv = 24'hA5C3E1;
    events = '0;
    out_of_idle = 1'b1;
    crc_cca_valid = 1'b0;
    gpio_out_req = 2'b10;
    gpio_oe_req = 2'b01;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk_val(miso_oe, 1'b0);
    chk_val(power_amp_enable, 1'b1);
    rdchk(tpsc_pkg::ADDR_POWER_STREAM, tpsc_pkg::PSC_RST);
    rdchk(tpsc_pkg::ADDR_POWER_AMP, tpsc_pkg::PAG_RST);
    rdchk(tpsc_pkg::ADDR_PIN_CLK_TMR, tpsc_pkg::PCT_RST);
    rdchk(tpsc_pkg::ADDR_CLKO_CTL, tpsc_pkg::CLKO_RST);
    rdchk(6'h3F, 16'h0000);
    span(40);
    chk_rng(tg, 39, 40);
    chk_rng(tk, 39, 40);
    // Load strobe rises once, a repeated one is ignored, a rearm loads again
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8800);
    chk_val(loads, 1);
    chk_val(event_timer_load_value, 24'hA5C3E1);
    @(negedge sys_clk) tcv = 24'h5A3C1E;
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8800);
    chk_val(loads, 1);
    i_tpsc_spi_host.rearm(16'h8800, rd);
    chk_val(loads, 2);
    chk_val(event_timer_load_value, 24'h5A3C1E);
    // Reserved bits take no value
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'hFFFC);
    rdchk(tpsc_pkg::ADDR_POWER_STREAM, 16'h8AE0);
    chk_val(loads, 2);
    wr(tpsc_pkg::ADDR_POWER_AMP, 16'h7FFF);
    rdchk(tpsc_pkg::ADDR_POWER_AMP, 16'h0000);
    chk_val(power_amp_enable, 1'b0);
    wr(tpsc_pkg::ADDR_PIN_CLK_TMR, 16'hFF58);
    rdchk(tpsc_pkg::ADDR_PIN_CLK_TMR, 16'h0000);
    span(40);
    chk_rng(tg, 0, 0);
    chk_val(clock_out_pin, 1'b0);
    chk_val({general_pin_out, general_pin_oe}, {gpio_out_req, gpio_oe_req});
    wr(tpsc_pkg::ADDR_PIN_CLK_TMR, 16'h00A3);
    chk_val(general_pin_out, 2'b01);
    @(negedge sys_clk) {crc_cca_valid, out_of_idle} = 2'b10;
    repeat (3) @(negedge sys_clk);
    chk_val(general_pin_out, 2'b10);
    span(80);
    chk_rng(tk, 9, 10);
    chk_rng(tg, 79, 80);
    wr(tpsc_pkg::ADDR_CLKO_CTL, 16'h7E02);
    span(80);
    chk_rng(tg, 19, 21);
    // Stream mode done flags, unmasked then masked
    chk_val(word_streaming, 1'b1);
    pulse('{send_finish: 1'b1, default: 1'b0});
    chk_val(interrupt_request_n, 1'b0);
    rdchk(tpsc_pkg::ADDR_STATUS, 16'h0001);
    chk_val(interrupt_request_n, 1'b1);
    pulse('{receive_finish: 1'b1, default: 1'b0});
    chk_val(interrupt_request_n, 1'b0);
    rdchk(tpsc_pkg::ADDR_STATUS, 16'h0002);
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8A20);
    pulse('{send_finish: 1'b1, receive_finish: 1'b1, default: 1'b0});
    chk_val(interrupt_request_n, 1'b1);
    rdchk(tpsc_pkg::ADDR_STATUS, 16'h0003);
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8A00);
    chk_val(word_streaming, 1'b0);
    pulse('{buffer_address_fault: 1'b1, default: 1'b0});
    rdchk(tpsc_pkg::ADDR_STATUS, 16'h0001);
    // Low power entry after the serial output is set to drive low
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8200);
    chk_val({miso_oe, miso_out}, 2'b10);
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8201);
    chk_val(timed_sleep_active, 1'b1);
    span(1000);
    chk_rng(tg, 6, 9);
    chk_rng(tk, 124, 125);
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8000);
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8001);
    repeat (150) @(negedge sys_clk);
    span(300);
    chk_rng(tg, 0, 0);
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h8002);
    chk_val({deep_sleep_active, timed_sleep_active}, 2'b10);
    span(200);
    chk_rng(tk, 0, 0);
    wr(tpsc_pkg::ADDR_POWER_STREAM, 16'h0000);
    chk_val({deep_sleep_active, timed_sleep_active}, 2'b00);
    // Clock enable low freezes the divided clock, high lets it run on
    @(negedge sys_clk) clk_en = 1'b0;
    repeat (2) @(negedge sys_clk);
    span(40);
    chk_rng(tg, 0, 0);
    @(negedge sys_clk) clk_en = 1'b1;
    span(40);
    chk_rng(tg, 9, 11);
    end_sim();
  end
endmodule
